// >>> shared/adcis_pkg.sv
package adcis_pkg;
   // special function register addresses
   localparam logic [7:0] ADCIS_MX_ADDR = 8'h96;
   localparam logic [7:0] ADCIS_REF_ADDR = 8'hD1;
   // input select register layout
   localparam logic [7:0] ADCIS_MX_RESET = 8'h1F;
   localparam int ADCIS_MX_CODE_MSB = 4;
   localparam int ADCIS_MX_CODE_W = 5;
   // reference control register layout
   localparam logic [7:0] ADCIS_REF_RESET = 8'h00;
   localparam int ADCIS_REF_SEL_LSB = 3;
   localparam int ADCIS_REF_GND_BIT = 5;
   localparam int ADCIS_REF_TEMP_BIT = 2;
   localparam logic [7:0] ADCIS_REF_RD_MASK = 8'h3C;
   // multiplexer codes
   localparam logic [4:0] ADCIS_CODE_P0_FIRST = 5'h01;
   localparam logic [4:0] ADCIS_CODE_P0_LAST = 5'h07;
   localparam logic [4:0] ADCIS_CODE_P1_2 = 5'h0A;
   localparam logic [4:0] ADCIS_CODE_P1_3 = 5'h0B;
   localparam logic [4:0] ADCIS_CODE_P1_4 = 5'h0C;
   localparam logic [4:0] ADCIS_CODE_TEMP = 5'h1B;
   localparam logic [4:0] ADCIS_CODE_VDD_A = 5'h1C;
   localparam logic [4:0] ADCIS_CODE_VREG = 5'h1D;
   localparam logic [4:0] ADCIS_CODE_VDD_B = 5'h1E;
   localparam logic [4:0] ADCIS_CODE_GND = 5'h1F;
   // reference source select encodings
   localparam logic [1:0] ADCIS_REF_EXT = 2'h0;
   localparam logic [1:0] ADCIS_REF_VDD = 2'h1;
   localparam logic [1:0] ADCIS_REF_VREG = 2'h2;
   localparam logic [1:0] ADCIS_REF_HS = 2'h3;

   typedef struct packed {
      logic [7:0] port0_sel;
      logic [7:0] port1_sel;
      logic temp_sel;
      logic vdd_sel;
      logic vreg_sel;
      logic gnd_sel;
   } adcis_route_s;

   typedef struct packed {
      logic ext_sel;
      logic vdd_sel;
      logic vreg_sel;
      logic hs_sel;
      logic hs_enable;
   } adcis_ref_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } adcis_sfr_req_s;
endpackage

// >>> src/adcis_select.sv
// Notes on behaviour
// R1: five-bit code in the input select register picks the positive input.
// R2: codes 1..7 route port 0 pins 1..7; 0A..0C route port 1 pins 2..4, pin 4 on the large package only.
// R3: 1B temperature sensor, 1C and 1E main supply, 1D core supply, 1F ground.
// R4: reference select 00 uses the external reference input.
// R5: reference select 11 uses the 1.65 V high-speed internal reference.
// R6: high-speed reference is enabled only while the converter needs it.
// R7: reference select 01 uses main supply, 10 the regulated digital supply.
// R8: ground select 1 takes ground from the analog ground pin except where R9 or R10 forces internal ground.
// R9: temperature sensor channel forces internal ground during sampling.
// R10: high-speed reference forces internal ground during conversion.
// R11: sensor enable bit powers sensor; off means high impedance, invalid result.
// R12: reserved codes connect nothing; top three register bits read zero.
`timescale 1ns/1ps
`default_nettype none
module adcis_select
   import adcis_pkg::*;
#(
   parameter bit LARGE_PACKAGE = 1'b1
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire adcis_sfr_req_s sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic adc_need_ref,
   input wire logic adc_tracking,
   input wire logic adc_converting,
   output adcis_route_s route,
   output adcis_ref_s ref_out,
   output logic analog_ground_pin_sel,
   output logic temp_sensor_enable,
   output logic temp_sensor_out_oe_n,
   output logic temp_result_invalid
);

   logic [4:0] positive_input_code_reg;
   logic [1:0] reference_source_select_reg;
   logic analog_ground_select_reg;
   logic temp_sensor_enable_reg;
   logic [7:0] rdata_reg;
   adcis_route_s route_reg;
   adcis_ref_s ref_reg;
   logic gnd_pin_reg;
   logic ts_oe_n_reg;
   logic ts_invalid_reg;
   logic wr_mx;
   logic wr_ref;

   function automatic adcis_route_s decode_route(input logic [4:0] code, input logic big_pkg);
      adcis_route_s r;
      r = '0;
      if (code >= ADCIS_CODE_P0_FIRST && code <= ADCIS_CODE_P0_LAST) begin
         r.port0_sel[code[2:0]] = 1'b1; // [R2]
      end
      case (code)
         ADCIS_CODE_P1_2: r.port1_sel[2] = 1'b1; // [R2]
         ADCIS_CODE_P1_3: r.port1_sel[3] = 1'b1;
         // pin 4 is bonded out only on the larger package
         ADCIS_CODE_P1_4: r.port1_sel[4] = big_pkg; // [R2]
         ADCIS_CODE_TEMP: r.temp_sel = 1'b1; // [R3]
         ADCIS_CODE_VDD_A, ADCIS_CODE_VDD_B: r.vdd_sel = 1'b1; // [R3]
         ADCIS_CODE_VREG: r.vreg_sel = 1'b1; // [R3]
         ADCIS_CODE_GND: r.gnd_sel = 1'b1; // [R3]
         default: r = r; // reserved codes leave every switch open [R12]
      endcase
      return r;
   endfunction

   assign wr_mx = sfr_req.wr && (sfr_req.addr == ADCIS_MX_ADDR);
   assign wr_ref = sfr_req.wr && (sfr_req.addr == ADCIS_REF_ADDR);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         positive_input_code_reg <= ADCIS_MX_RESET[ADCIS_MX_CODE_MSB:0];
      end else if (wr_mx) begin
         // bits 7:5 are not stored, so they ignore writes [R12]
         positive_input_code_reg <= sfr_req.wdata[ADCIS_MX_CODE_MSB:0]; // [R1]
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reference_source_select_reg <= ADCIS_REF_RESET[ADCIS_REF_SEL_LSB+1:ADCIS_REF_SEL_LSB];
         analog_ground_select_reg <= ADCIS_REF_RESET[ADCIS_REF_GND_BIT];
         temp_sensor_enable_reg <= ADCIS_REF_RESET[ADCIS_REF_TEMP_BIT];
      end else if (wr_ref) begin
         reference_source_select_reg <= sfr_req.wdata[ADCIS_REF_SEL_LSB+1:ADCIS_REF_SEL_LSB];
         analog_ground_select_reg <= sfr_req.wdata[ADCIS_REF_GND_BIT];
         temp_sensor_enable_reg <= sfr_req.wdata[ADCIS_REF_TEMP_BIT]; // [R11]
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= 8'h00;
      end else if (sfr_req.rd) begin
         case (sfr_req.addr)
            ADCIS_MX_ADDR: rdata_reg <= {3'h0, positive_input_code_reg}; // [R12]
            ADCIS_REF_ADDR: begin
               rdata_reg <= ADCIS_REF_RD_MASK & {2'h0, analog_ground_select_reg,
                  reference_source_select_reg, temp_sensor_enable_reg, 2'h0};
            end
            default: rdata_reg <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         route_reg <= '0;
      end else begin
         route_reg <= decode_route(positive_input_code_reg, LARGE_PACKAGE); // [R1]
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ref_reg <= '0;
      end else begin
         ref_reg.ext_sel <= (reference_source_select_reg == ADCIS_REF_EXT); // [R4]
         ref_reg.vdd_sel <= (reference_source_select_reg == ADCIS_REF_VDD); // [R7]
         ref_reg.vreg_sel <= (reference_source_select_reg == ADCIS_REF_VREG); // [R7]
         ref_reg.hs_sel <= (reference_source_select_reg == ADCIS_REF_HS); // [R5]
         // powered on demand to save the reference's standing current
         ref_reg.hs_enable <= (reference_source_select_reg == ADCIS_REF_HS)
            && adc_need_ref; // [R6]
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         gnd_pin_reg <= 1'b0;
      end else begin
         // the pin is used only where no internal-ground override applies
         gnd_pin_reg <= analog_ground_select_reg // [R8]
            && !(positive_input_code_reg == ADCIS_CODE_TEMP && adc_tracking) // [R9]
            && !(reference_source_select_reg == ADCIS_REF_HS && adc_converting); // [R10]
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ts_oe_n_reg <= 1'b1;
         ts_invalid_reg <= 1'b0;
      end else begin
         ts_oe_n_reg <= !temp_sensor_enable_reg; // [R11]
         ts_invalid_reg <= !temp_sensor_enable_reg
            && (positive_input_code_reg == ADCIS_CODE_TEMP); // [R11]
      end
   end

   assign sfr_rdata = rdata_reg;
   assign route = route_reg;
   assign ref_out = ref_reg;
   assign analog_ground_pin_sel = gnd_pin_reg;
   assign temp_sensor_enable = temp_sensor_enable_reg;
   assign temp_sensor_out_oe_n = ts_oe_n_reg;
   assign temp_result_invalid = ts_invalid_reg;

   sequence s_mx_write(logic [4:0] c);
      wr_mx && sfr_req.wdata[4:0] == c;
   endsequence

   sequence s_ref_write(logic [1:0] s);
      wr_ref && sfr_req.wdata[ADCIS_REF_SEL_LSB+1:ADCIS_REF_SEL_LSB] == s;
   endsequence

   property p_code_holds;
      @(posedge clk_sys) disable iff (!resetn)
      !wr_mx |=> $stable(positive_input_code_reg);
   endproperty
   a_code_holds: assert property (p_code_holds) else $error("code changed without write"); // [R1]

   property p_port0_route;
      @(posedge clk_sys) disable iff (!resetn)
      s_mx_write(5'h05) ##1 !wr_mx |=> route.port0_sel == 8'h20 && route.port1_sel == 8'h00;
   endproperty
   a_port0_route: assert property (p_port0_route) else $error("port0 pin 5 not routed"); // [R2]

   property p_temp_route;
      @(posedge clk_sys) disable iff (!resetn)
      s_mx_write(ADCIS_CODE_TEMP) ##1 !wr_mx |=> route.temp_sel && !route.vdd_sel;
   endproperty
   a_temp_route: assert property (p_temp_route) else $error("temperature code not routed"); // [R3]

   property p_ext_ref;
      @(posedge clk_sys) disable iff (!resetn)
      s_ref_write(ADCIS_REF_EXT) ##1 !wr_ref |=> ref_out.ext_sel && !ref_out.hs_sel;
   endproperty
   a_ext_ref: assert property (p_ext_ref) else $error("external reference not chosen"); // [R4]

   property p_hs_ref;
      @(posedge clk_sys) disable iff (!resetn)
      s_ref_write(ADCIS_REF_HS) ##1 !wr_ref |=> ref_out.hs_sel && !ref_out.ext_sel;
   endproperty
   a_hs_ref: assert property (p_hs_ref) else $error("high-speed reference not chosen"); // [R5]

   property p_hs_on_demand;
      @(posedge clk_sys) disable iff (!resetn)
      ##1 ref_out.hs_enable |-> $past(adc_need_ref) && ref_out.hs_sel;
   endproperty
   a_hs_on_demand: assert property (p_hs_on_demand) else $error("reference on unneeded"); // [R6]

   property p_vdd_ref;
      @(posedge clk_sys) disable iff (!resetn)
      s_ref_write(ADCIS_REF_VDD) ##1 !wr_ref |=> ref_out.vdd_sel && !ref_out.vreg_sel;
   endproperty
   a_vdd_ref: assert property (p_vdd_ref) else $error("supply reference not chosen"); // [R7]

   property p_ground_pin;
      @(posedge clk_sys) disable iff (!resetn)
      analog_ground_select_reg && positive_input_code_reg != ADCIS_CODE_TEMP
         && reference_source_select_reg != ADCIS_REF_HS |=> analog_ground_pin_sel;
   endproperty
   a_ground_pin: assert property (p_ground_pin) else $error("ground pin not used"); // [R8]

   property p_temp_gnd;
      @(posedge clk_sys) disable iff (!resetn)
      positive_input_code_reg == ADCIS_CODE_TEMP && adc_tracking |=> !analog_ground_pin_sel;
   endproperty
   a_temp_gnd: assert property (p_temp_gnd) else $error("pin ground used on sensor"); // [R9]

   property p_hs_gnd;
      @(posedge clk_sys) disable iff (!resetn)
      reference_source_select_reg == ADCIS_REF_HS && adc_converting |=> !analog_ground_pin_sel;
   endproperty
   a_hs_gnd: assert property (p_hs_gnd) else $error("pin ground used in conversion"); // [R10]

   property p_sensor_off;
      @(posedge clk_sys) disable iff (!resetn)
      !temp_sensor_enable ##1 !temp_sensor_enable |-> temp_sensor_out_oe_n;
   endproperty
   a_sensor_off: assert property (p_sensor_off) else $error("sensor drives while off"); // [R11]

   property p_reserved;
      @(posedge clk_sys) disable iff (!resetn)
      s_mx_write(5'h10) ##1 !wr_mx |=> route == '0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code connected"); // [R12]

   property p_ref_hold;
      @(posedge clk_sys) disable iff (!resetn)
      !wr_ref |=> $stable({reference_source_select_reg, analog_ground_select_reg,
         temp_sensor_enable_reg});
   endproperty
   a_ref_hold: assert property (p_ref_hold) else $error("settings changed without write"); // [R7]

   property p_gnd_route;
      @(posedge clk_sys) disable iff (!resetn)
      s_mx_write(ADCIS_CODE_GND) ##1 !wr_mx |=> route.gnd_sel && !route.temp_sel;
   endproperty
   a_gnd_route: assert property (p_gnd_route) else $error("ground code not routed"); // [R3]

   property p_port1_route;
      @(posedge clk_sys) disable iff (!resetn)
      s_mx_write(ADCIS_CODE_P1_4) ##1 !wr_mx |=> route.port1_sel == {3'h0, LARGE_PACKAGE, 4'h0};
   endproperty
   a_port1_route: assert property (p_port1_route) else $error("pin 4 routing wrong"); // [R2]

   property p_vreg_ref;
      @(posedge clk_sys) disable iff (!resetn)
      s_ref_write(ADCIS_REF_VREG) ##1 !wr_ref |=> ref_out.vreg_sel && !ref_out.vdd_sel;
   endproperty
   a_vreg_ref: assert property (p_vreg_ref) else $error("regulated reference not chosen"); // [R7]

   property p_ref_onehot;
      @(posedge clk_sys) disable iff (!resetn)
      1'b1 |=> $onehot({ref_out.ext_sel, ref_out.vdd_sel, ref_out.vreg_sel, ref_out.hs_sel});
   endproperty
   a_ref_onehot: assert property (p_ref_onehot) else $error("not exactly one reference"); // [R4]

   property p_hs_needed;
      @(posedge clk_sys) disable iff (!resetn)
      reference_source_select_reg == ADCIS_REF_HS && adc_need_ref |=> ref_out.hs_enable;
   endproperty
   a_hs_needed: assert property (p_hs_needed) else $error("reference off while needed"); // [R6]

   property p_hs_idle;
      @(posedge clk_sys) disable iff (!resetn)
      !adc_need_ref |=> !ref_out.hs_enable;
   endproperty
   a_hs_idle: assert property (p_hs_idle) else $error("reference on while idle"); // [R6]

   property p_mx_read;
      @(posedge clk_sys) disable iff (!resetn)
      sfr_req.rd && sfr_req.addr == ADCIS_MX_ADDR
         |=> sfr_rdata == {3'h0, $past(positive_input_code_reg)};
   endproperty
   a_mx_read: assert property (p_mx_read) else $error("input select read wrong"); // [R12]

   property p_rdata_hold;
      @(posedge clk_sys) disable iff (!resetn)
      !sfr_req.rd |=> $stable(sfr_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // [R1]

   property p_sensor_on;
      @(posedge clk_sys) disable iff (!resetn)
      temp_sensor_enable |=> !temp_sensor_out_oe_n && !temp_result_invalid;
   endproperty
   a_sensor_on: assert property (p_sensor_on) else $error("sensor idle while enabled"); // [R11]

   property p_invalid;
      @(posedge clk_sys) disable iff (!resetn)
      !temp_sensor_enable && positive_input_code_reg == ADCIS_CODE_TEMP |=> temp_result_invalid;
   endproperty
   a_invalid: assert property (p_invalid) else $error("dead sensor result not flagged"); // [R11]

endmodule
`default_nettype wire

// >>> testbench/adcis_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcis_adc_model (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [1:0] phase,
   output logic adc_need_ref,
   output logic adc_tracking,
   output logic adc_converting
);
   // phase 0 idle, 1 tracking, 2 converting, 3 reference warm-up only
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         adc_need_ref <= 1'b0;
         adc_tracking <= 1'b0;
         adc_converting <= 1'b0;
      end else begin
         adc_need_ref <= (phase != 2'h0);
         adc_tracking <= (phase == 2'h1);
         adc_converting <= (phase == 2'h2);
      end
   end
endmodule
`default_nettype wire

// >>> testbench/adc_input_reference_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_input_reference_select_tb;
   import adcis_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   adcis_sfr_req_s sfr_req = '0;
   logic [7:0] sfr_rdata;
   logic [1:0] phase = 2'h0;
   logic need_ref, tracking, converting;
   adcis_route_s route;
   adcis_ref_s ref_out;
   logic gnd_pin, tse, oe_n, inval;
   adcis_route_s route_small;
   logic [7:0] rd;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;

   always #20 clk_sys = ~clk_sys;

   adcis_adc_model model (.clk_sys(clk_sys), .resetn(resetn), .phase(phase),
      .adc_need_ref(need_ref), .adc_tracking(tracking), .adc_converting(converting));

   adcis_select dut (.clk_sys(clk_sys), .resetn(resetn), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .adc_need_ref(need_ref), .adc_tracking(tracking),
      .adc_converting(converting), .route(route), .ref_out(ref_out),
      .analog_ground_pin_sel(gnd_pin), .temp_sensor_enable(tse),
      .temp_sensor_out_oe_n(oe_n), .temp_result_invalid(inval));

   // small-package build: port 1 pin 4 is not bonded out
   adcis_select #(.LARGE_PACKAGE(1'b0)) dut_small (.clk_sys(clk_sys), .resetn(resetn),
      .sfr_req(sfr_req), .sfr_rdata(), .adc_need_ref(need_ref), .adc_tracking(tracking),
      .adc_converting(converting), .route(route_small), .ref_out(),
      .analog_ground_pin_sel(), .temp_sensor_enable(), .temp_sensor_out_oe_n(),
      .temp_result_invalid());

   task automatic conclude();
      $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // whole run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         conclude();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // route and reference outputs settle one edge after the write edge; the task waits two
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      sfr_req.addr = a;
      sfr_req.wdata = d;
      sfr_req.wr = 1'b1;
      tick(1);
      sfr_req.wr = 1'b0;
      tick(2);
   endtask

   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
      sfr_req.addr = a;
      sfr_req.rd = 1'b1;
      tick(1);
      sfr_req.rd = 1'b0;
      tick(1);
      d = sfr_rdata;
   endtask

   function automatic adcis_route_s exp_route(input logic [4:0] c);
      adcis_route_s r;
      r = '0;
      if (c >= 5'h01 && c <= 5'h07) r.port0_sel[c[2:0]] = 1'b1;
      if (c >= 5'h0A && c <= 5'h0C) r.port1_sel[c[2:0]] = 1'b1;
      r.temp_sel = (c == 5'h1B);
      r.vdd_sel = (c == 5'h1C) || (c == 5'h1E);
      r.vreg_sel = (c == 5'h1D);
      r.gnd_sel = (c == 5'h1F);
      return r;
   endfunction

   task automatic t_reset();
      check(route, 32'h1);
      check(ref_out, 32'h10);
      sfr_read(8'h96, rd);
      check(rd, 32'h1F);
      sfr_read(8'hD1, rd);
      check(rd, 32'h0);
      sfr_write(8'h97, 8'hFF);
      sfr_read(8'h97, rd);
      check(rd, 32'h0);
      sfr_read(8'h96, rd);
      check(rd, 32'h1F);
      $display("test reset done");
   endtask

   task automatic t_mux();
      adcis_route_s exp_small;
      for (int c = 0; c < 32; c++) begin
         sfr_write(8'h96, {3'h7, c[4:0]});
         check(route, exp_route(c[4:0]));
         exp_small = exp_route(c[4:0]);
         exp_small.port1_sel[4] = 1'b0;
         check(route_small, exp_small);
         sfr_read(8'h96, rd);
         check(rd, {27'h0, c[4:0]});
      end
      $display("test mux done");
   endtask

   task automatic t_ref();
      for (int s = 0; s < 4; s++) begin
         sfr_write(8'hD1, {3'h0, s[1:0], 3'h0});
         phase = 2'h3;
         tick(2);
         check(ref_out, {s == 0, s == 1, s == 2, s == 3, s == 3});
         phase = 2'h0;
         tick(2);
         check(ref_out.hs_enable, 32'h0);
      end
      $display("test reference done");
   endtask

   task automatic t_gnd();
      logic e;
      for (int i = 0; i < 5; i++) begin
         sfr_write(8'h96, i[0] ? 8'h1B : 8'h05);
         sfr_write(8'hD1, {2'h0, i < 4, i[1] ? 2'h3 : 2'h0, 3'h4});
         for (int p = 0; p < 3; p++) begin
            phase = p[1:0];
            tick(2);
            e = (i < 4) && !(i[0] && p == 1) && !(i[1] && p == 2);
            check(gnd_pin, e);
         end
      end
      phase = 2'h0;
      $display("test ground done");
   endtask

   task automatic t_temp();
      sfr_write(8'h96, 8'h1B);
      sfr_write(8'hD1, 8'h00);
      check({tse, oe_n, inval}, 32'h3);
      sfr_write(8'hD1, 8'h04);
      check({tse, oe_n, inval}, 32'h4);
      sfr_read(8'hD1, rd);
      check(rd, 32'h4);
      $display("test sensor done");
   endtask

   task automatic t_midreset();
      sfr_write(8'hD1, 8'h3C);
      resetn = 1'b0;
      tick(2);
      check(route, 32'h0);
      check(ref_out, 32'h0);
      check(oe_n, 32'h1);
      resetn = 1'b1;
      tick(1);
      check(route, 32'h1);
      check(ref_out, 32'h10);
      check(tse, 32'h0);
      sfr_read(8'h96, rd);
      check(rd, 32'h1F);
      $display("test mid-run reset done");
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      tick(1);
      t_reset();
      t_mux();
      t_ref();
      t_gnd();
      t_temp();
      t_midreset();
      conclude();
   end
endmodule
`default_nettype wire
